// [src/seqrd_regs.svh]
// register offsets, field positions and reset values of the sequencer stage
`ifndef SEQRD_REGS_SVH
`define SEQRD_REGS_SVH
`define SEQRD_ADR_CFG 8'h00
`define SEQRD_ADR_INIT_PAT 8'h04
`define SEQRD_ADR_STATUS 8'h08
`define SEQRD_ADR_FUSE_ADDR 8'h0c
`define SEQRD_ADR_FUSE_W0 8'h10
`define SEQRD_ADR_FUSE_W1 8'h14
`define SEQRD_ADR_FUSE_W2 8'h18
`define SEQRD_ADR_FUSE_GO 8'h1c
`define SEQRD_CFG_INIT_SEL_BIT 0
`define SEQRD_CFG_SECONDARY_CLOCK_EN_BIT 1
`define SEQRD_CFG_RST 2'h1
`define SEQRD_INIT_PAT_RST 16'h0000
`define SEQRD_PWRUP_BITS 8'hff
`define SEQRD_FUSE_W2_BITS 23
`define SEQRD_LAST_TERM 6'h3f
`endif

// [src/seqrd_pkg.sv]
// types shared by the sequencer register stage
package seqrd_pkg;
  // one transition term: and-array literals, or-array links, complement link
  typedef struct packed {
    logic term_en;
    logic [1:0] comp_con;
    logic [15:0] or_k;
    logic [15:0] or_j;
    logic [25:0] and_f;
    logic [25:0] and_t;
  } seqrd_fuse_t;
  // register update mode chosen from the diagnostic selects
  typedef enum logic [1:0] {
    SEQRD_RUN,
    SEQRD_READOUT,
    SEQRD_STATE_LOAD,
    SEQRD_OUT_LOAD
  } seqrd_mode_t;
endpackage : seqrd_pkg

// [src/seqrd_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module seqrd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } seqrd_sync_st_t;
  seqrd_sync_st_t st_q;
  seqrd_sync_st_t st_d;

  // first stage feeds only the second
  always_comb
  begin
    st_d.meta = async_i;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.stable;
endmodule : seqrd_sync

// [src/seqrd_fuse_mem.sv]
// transition term store, one word per term, registered read
`timescale 1ns/1ns
module seqrd_fuse_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int DW = 87
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // programming write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // scan read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } seqrd_mem_st_t;
  seqrd_mem_st_t st_q;
  seqrd_mem_st_t st_d;

  // cleared store: every term disabled, every link open
  always_comb
  begin
    st_d = st_q;
    st_d.rd = st_q.mem[rd_addr_i];
    if (wr_en_i)
    begin
      st_d.mem[wr_addr_i] = wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rd_data_o = st_q.rd;
endmodule : seqrd_fuse_mem

// [src/seqrd_top.sv]
// sequencer state/output register stage with diagnostic modes
// Behaviour
// - state-load select: pins captured into state bits on edge; output bits hold
// - output-load select: pins captured into output bits on edge; state bits hold
// - readout select: pins show state bits; neither register changes
// - normal enabled operation: pins driven from output register bits
// - diagnostic pins at logic level act as ordinary array inputs ten to twelve; here they only select modes and never reach the array
// - init function with pin high forces every bit to its programmed value
// - init beats the clock; edges ignored while init is held high
// - after init falls, updates resume after the next falling clock transition
// - enable function: pin high tri-states outputs, registers untouched
// - dual-function pin is either init or output enable, never both
// - each bit is a J-K flip-flop: hold, clear, set, toggle
// - power-up presets every state and output bit to one
// - load modes tri-state outputs; fixture drives pins before the edge
// - unprogrammed: init function, terms inactive, drives zero, second clock off
// - each J/K drive is OR of up to 64 product terms
// - rising edges only; second clock, when on, runs the upper four bits
// - complement output high only when no connected term is active
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`include "seqrd_regs.svh"
module seqrd_top #(
  parameter int NTERM = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sequencer pins
  input wire logic primary_clock_i,
  input wire logic secondary_clock_i,
  input wire logic [15:0] ext_in_i,
  input wire logic init_oe_pin_i,
  input wire logic output_load_diag_input_i,
  input wire logic state_load_diag_input_i,
  input wire logic state_readout_diag_input_i,
  // three-state output pins
  input wire logic [7:0] sequencer_output_pins_i,
  output logic [7:0] sequencer_output_pins_o,
  output logic [7:0] sequencer_output_pins_oe_o
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic init_sel;
    logic secondary_clock_en;
    logic [15:0] init_pat;
    logic [5:0] fuse_addr;
    logic [86:0] fuse_buf;
    logic [5:0] scan;
    logic [5:0] tag;
    logic [15:0] acc_j;
    logic [15:0] acc_k;
    logic [1:0] acc_c;
    logic [15:0] jk_j;
    logic [15:0] jk_k;
    logic [1:0] comp;
    logic primary_clock_prev;
    logic secondary_clock_prev;
    logic [1:0] armed;
    logic [7:0] state_bits;
    logic [7:0] output_reg_bits;
    logic [7:0] pins;
    logic [7:0] pins_oe;
  } seqrd_top_st_t;
  seqrd_top_st_t st_q;
  seqrd_top_st_t st_d;
  // reset value of the configuration word
  localparam logic [1:0] cfg_rst = `SEQRD_CFG_RST;

  logic [29:0] pin_s;
  logic [86:0] fuse_rd;
  logic fuse_we;
  seqrd_pkg::seqrd_fuse_t term;
  seqrd_pkg::seqrd_mode_t mode;
  logic [25:0] vars;
  logic term_act;
  logic init_act;
  logic primary_clock_s;
  logic secondary_clock_s;
  logic [15:0] ext_s;
  logic [7:0] fpin_s;
  logic [1:0] rise;
  logic [1:0] fall;
  logic wb_req;
  logic [7:0] adr;

  // byte-lane merge for register writes
  function automatic logic [31:0] seqrd_merge(input logic [31:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction : seqrd_merge

  // one J-K flip-flop step
  function automatic logic seqrd_jk(input logic q, input logic j, input logic k);
    logic res;
    res = q;
    if (j && k)
    begin
      res = ~q;
    end
    else if (j)
    begin
      res = 1'h1;
    end
    else if (k)
    begin
      res = 1'h0;
    end
    return res;
  endfunction : seqrd_jk

  // every pin passes two flops first
  seqrd_sync #(
    .WIDTH(30)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({state_readout_diag_input_i, state_load_diag_input_i, output_load_diag_input_i,
              init_oe_pin_i, secondary_clock_i, primary_clock_i, sequencer_output_pins_i,
              ext_in_i}),
    .sync_o(pin_s)
  );

  // term store scanned one word per cycle
  seqrd_fuse_mem #(
    .DEPTH(NTERM),
    .AW(6),
    .DW(87)
  ) u_fuse (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(fuse_we),
    .wr_addr_i(st_q.fuse_addr),
    .wr_data_i(st_q.fuse_buf),
    .rd_addr_i(st_q.scan),
    .rd_data_o(fuse_rd)
  );

  // pin fields and edge detection
  always_comb
  begin
    ext_s = pin_s[15:0];
    fpin_s = pin_s[23:16];
    primary_clock_s = pin_s[24];
    secondary_clock_s = pin_s[25];
    rise[0] = primary_clock_s & ~st_q.primary_clock_prev;
    rise[1] = st_q.secondary_clock_en ? (secondary_clock_s & ~st_q.secondary_clock_prev) : rise[0];
    fall[0] = ~primary_clock_s & st_q.primary_clock_prev;
    fall[1] = st_q.secondary_clock_en ? (~secondary_clock_s & st_q.secondary_clock_prev) : fall[0];
    // one programmed function for the shared pin
    init_act = st_q.init_sel & pin_s[26];
    if (pin_s[28])
    begin
      mode = seqrd_pkg::SEQRD_STATE_LOAD;
    end
    else if (pin_s[27])
    begin
      mode = seqrd_pkg::SEQRD_OUT_LOAD;
    end
    else if (pin_s[29])
    begin
      mode = seqrd_pkg::SEQRD_READOUT;
    end
    else
    begin
      mode = seqrd_pkg::SEQRD_RUN;
    end
  end

  // product term of the word now read out
  always_comb
  begin
    term = seqrd_pkg::seqrd_fuse_t'(fuse_rd);
    // array inputs: complement bits, state bits, external inputs; no diagnostic pins
    vars = {st_q.comp, st_q.state_bits, ext_s};
    // and over true and false literals
    term_act = term.term_en & (&(~term.and_t | vars)) & (&(~term.and_f | ~vars));
  end

  // bus decode
  always_comb
  begin
    wb_req = wb_cyc_i & wb_stb_i & ~st_q.ack;
    adr = {wb_adr_i[7:2], 2'h0};
    fuse_we = wb_req & wb_we_i & (adr == `SEQRD_ADR_FUSE_GO);
  end

  always_comb
  begin
    st_d = st_q;
    // wishbone: ack one cycle after the request, dropped next cycle
    st_d.ack = wb_req;
    st_d.rdat = 32'h0000_0000;
    if (wb_req && wb_we_i)
    begin
      if (adr == `SEQRD_ADR_CFG)
      begin
        if (wb_sel_i[0])
        begin
          st_d.init_sel = wb_dat_i[`SEQRD_CFG_INIT_SEL_BIT];
          st_d.secondary_clock_en = wb_dat_i[`SEQRD_CFG_SECONDARY_CLOCK_EN_BIT];
        end
      end
      else if (adr == `SEQRD_ADR_INIT_PAT)
      begin
        st_d.init_pat = 16'(seqrd_merge({16'h0000, st_q.init_pat}, wb_dat_i, wb_sel_i));
      end
      else if (adr == `SEQRD_ADR_FUSE_ADDR)
      begin
        if (wb_sel_i[0])
        begin
          st_d.fuse_addr = wb_dat_i[5:0];
        end
      end
      else if (adr == `SEQRD_ADR_FUSE_W0)
      begin
        st_d.fuse_buf[31:0] = seqrd_merge(st_q.fuse_buf[31:0], wb_dat_i, wb_sel_i);
      end
      else if (adr == `SEQRD_ADR_FUSE_W1)
      begin
        st_d.fuse_buf[63:32] = seqrd_merge(st_q.fuse_buf[63:32], wb_dat_i, wb_sel_i);
      end
      else if (adr == `SEQRD_ADR_FUSE_W2)
      begin
        st_d.fuse_buf[86:64] = `SEQRD_FUSE_W2_BITS'(seqrd_merge({9'h000, st_q.fuse_buf[86:64]},
                                                               wb_dat_i, wb_sel_i));
      end
    end
    else if (wb_req)
    begin
      if (adr == `SEQRD_ADR_CFG)
      begin
        st_d.rdat = {30'h0000_0000, st_q.secondary_clock_en, st_q.init_sel};
      end
      else if (adr == `SEQRD_ADR_INIT_PAT)
      begin
        st_d.rdat = {16'h0000, st_q.init_pat};
      end
      else if (adr == `SEQRD_ADR_STATUS)
      begin
        st_d.rdat = {16'h0000, st_q.output_reg_bits, st_q.state_bits};
      end
      else if (adr == `SEQRD_ADR_FUSE_ADDR)
      begin
        st_d.rdat = {26'h000_0000, st_q.fuse_addr};
      end
      else if (adr == `SEQRD_ADR_FUSE_W0)
      begin
        st_d.rdat = st_q.fuse_buf[31:0];
      end
      else if (adr == `SEQRD_ADR_FUSE_W1)
      begin
        st_d.rdat = st_q.fuse_buf[63:32];
      end
      else if (adr == `SEQRD_ADR_FUSE_W2)
      begin
        st_d.rdat = {9'h000, st_q.fuse_buf[86:64]};
      end
    end

    // accumulate or-array over the full term scan
    st_d.scan = st_q.scan + 6'h01;
    st_d.tag = st_q.scan;
    st_d.acc_j = st_q.acc_j | (term_act ? term.or_j : 16'h0000);
    st_d.acc_k = st_q.acc_k | (term_act ? term.or_k : 16'h0000);
    st_d.acc_c = st_q.acc_c | (term_act ? term.comp_con : 2'h0);
    if (st_q.tag == `SEQRD_LAST_TERM)
    begin
      st_d.jk_j = st_d.acc_j;
      st_d.jk_k = st_d.acc_k;
      // complement high when no linked term fired
      st_d.comp = ~st_d.acc_c;
      st_d.acc_j = 16'h0000;
      st_d.acc_k = 16'h0000;
      st_d.acc_c = 2'h0;
    end

    st_d.primary_clock_prev = primary_clock_s;
    st_d.secondary_clock_prev = secondary_clock_s;
    if (init_act)
    begin
      st_d.state_bits = st_q.init_pat[7:0];
      st_d.output_reg_bits = st_q.init_pat[15:8];
      st_d.armed = 2'h0;
    end
    else
    begin
      for (int h = 0; h < 2; h++)
      begin
        // first full pulse after a falling edge
        if (!st_q.armed[h])
        begin
          st_d.armed[h] = fall[h];
        end
        else if (rise[h])
        begin
          for (int i = 4 * h; i < 4 * h + 4; i++)
          begin
            case (mode)
              seqrd_pkg::SEQRD_STATE_LOAD: st_d.state_bits[i] = fpin_s[i];
              seqrd_pkg::SEQRD_OUT_LOAD: st_d.output_reg_bits[i] = fpin_s[i];
              seqrd_pkg::SEQRD_READOUT: st_d.state_bits[i] = st_q.state_bits[i];
              default:
              begin
                st_d.state_bits[i] = seqrd_jk(st_q.state_bits[i], st_q.jk_j[i], st_q.jk_k[i]);
                st_d.output_reg_bits[i] = seqrd_jk(st_q.output_reg_bits[i], st_q.jk_j[i + 8],
                                                   st_q.jk_k[i + 8]);
              end
            endcase
          end
        end
      end
    end

    // readout shows state bits, else output bits
    st_d.pins = (mode == seqrd_pkg::SEQRD_READOUT) ? st_d.state_bits : st_d.output_reg_bits;
    // load modes release the pins; enable function
    if (mode == seqrd_pkg::SEQRD_STATE_LOAD || mode == seqrd_pkg::SEQRD_OUT_LOAD ||
        (!st_q.init_sel && pin_s[26]))
    begin
      st_d.pins_oe = 8'h00;
    end
    else
    begin
      st_d.pins_oe = 8'hff;
    end
  end

  // power-up preset; init function, drives zero, clock two off
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= '0;
      st_q.init_sel <= cfg_rst[`SEQRD_CFG_INIT_SEL_BIT];
      st_q.secondary_clock_en <= cfg_rst[`SEQRD_CFG_SECONDARY_CLOCK_EN_BIT];
      st_q.init_pat <= `SEQRD_INIT_PAT_RST;
      st_q.comp <= 2'h3;
      st_q.state_bits <= `SEQRD_PWRUP_BITS;
      st_q.output_reg_bits <= `SEQRD_PWRUP_BITS;
      st_q.pins <= `SEQRD_PWRUP_BITS;
      st_q.pins_oe <= 8'hff;
      st_q.armed <= 2'h3;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdat;
  assign sequencer_output_pins_o = st_q.pins;
  assign sequencer_output_pins_oe_o = st_q.pins_oe;
endmodule : seqrd_top

// [dv/seqrd_top_sva.sv]
// port assertions for the sequencer register stage
`timescale 1ns/1ns
module seqrd_top_chk #(
  parameter int NTERM = 64
) (
  // watched ports
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic primary_clock_i,
  input wire logic secondary_clock_i,
  input wire logic init_oe_pin_i,
  input wire logic output_load_diag_input_i,
  input wire logic state_load_diag_input_i,
  input wire logic state_readout_diag_input_i,
  input wire logic [7:0] sequencer_output_pins_i,
  input wire logic [7:0] sequencer_output_pins_o,
  input wire logic [7:0] sequencer_output_pins_oe_o
);
  logic [3:0] quiet_q;
  logic load_w;
  logic read_w;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // load or readout select with the dual pin low
  assign load_w = (state_load_diag_input_i || output_load_diag_input_i) && !init_oe_pin_i;
  assign read_w = state_readout_diag_input_i && !load_w && !init_oe_pin_i;
  // cycles with pins and bus idle
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
      quiet_q <= 4'h0;
    else if (wb_cyc_i || !$stable({primary_clock_i, secondary_clock_i, init_oe_pin_i, load_w, read_w,
                                   sequencer_output_pins_i}))
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;
  sequence load_held_s; load_w [*6]; endsequence
  sequence read_held_s; read_w [*8]; endsequence
  sequence bus_req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  ack_follow_a: assert property (bus_req_s |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  oe_uniform_a: assert property (sequencer_output_pins_oe_o inside {8'h00, 8'hff})
    else $error("output enables differ");
  load_tristate_a: assert property (load_held_s |-> sequencer_output_pins_oe_o == 8'h00)
    else $error("pins driven in load mode");
  readout_drive_a: assert property (read_held_s |->
    sequencer_output_pins_oe_o == 8'hff && $stable(sequencer_output_pins_o))
    else $error("readout pins not steady");
  quiet_hold_a: assert property (quiet_q >= 4'h6 |->
    $stable(sequencer_output_pins_o) && $stable(sequencer_output_pins_oe_o))
    else $error("pins changed without clock");
  reset_vals_a: assert property ($rose(reset_n_i) |->
    sequencer_output_pins_o == 8'hff && sequencer_output_pins_oe_o == 8'hff)
    else $error("pins not preset after reset");
endmodule : seqrd_top_chk
bind seqrd_top seqrd_top_chk #(.NTERM(NTERM)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .primary_clock_i(primary_clock_i),
  .secondary_clock_i(secondary_clock_i),
  .init_oe_pin_i(init_oe_pin_i), .output_load_diag_input_i(output_load_diag_input_i),
  .state_load_diag_input_i(state_load_diag_input_i),
  .state_readout_diag_input_i(state_readout_diag_input_i),
  .sequencer_output_pins_i(sequencer_output_pins_i),
  .sequencer_output_pins_o(sequencer_output_pins_o),
  .sequencer_output_pins_oe_o(sequencer_output_pins_oe_o));

// [dv/seqrd_fixture.sv]
// test fixture model: pin clock pulses and output pin drive
`timescale 1ns/1ns
module seqrd_fixture (
  // clock and requests
  input wire logic clk_i,
  input wire logic pulse_i,
  input wire logic drv_en_i,
  input wire logic [7:0] drv_val_i,
  // design pin side
  input wire logic [7:0] dut_pin_i,
  input wire logic [7:0] dut_oe_i,
  // outputs
  output logic pin_clk_o,
  output logic busy_o,
  output logic [7:0] pin_o
);
  logic [4:0] cnt_q = 5'h0;
  logic [7:0] last_q = 8'h0;
  always_comb
    for (int i = 0; i < 8; i++)
      pin_o[i] = dut_oe_i[i] ? dut_pin_i[i] : (drv_en_i ? drv_val_i[i] : ~last_q[i]);
  // floating pins flip every cycle
  always_ff @(posedge clk_i)
    last_q <= pin_o;
  // one pulse, six high six low
  always_ff @(posedge clk_i)
    if (cnt_q != 5'h0)
      cnt_q <= cnt_q - 5'h1;
    else if (pulse_i)
      cnt_q <= 5'hc;
  assign pin_clk_o = cnt_q > 5'h6;
  assign busy_o = cnt_q != 5'h0;
endmodule : seqrd_fixture

// [dv/tb_top.sv]
// directed testbench for the sequencer register stage
`timescale 1ns/1ns
`include "seqrd_regs.svh"
module tb_top;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, pclk, busy, pulse = 1'h0;
  logic init_pin = 1'h0, ol = 1'h0, sl = 1'h0, ro = 1'h0, drv_en = 1'h0;
  logic [7:0] adr = 8'h0, drv_val = 8'h0, pin_lvl, pin_o, pin_oe;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic pulse2 = 1'h0, sclk, busy2;
  logic [15:0] ext = 16'h0000;
  int error_cnt = 0, n_compared = 0, cyc_cnt = 0;
  always #20 clk_i = ~clk_i;
  seqrd_top #(.NTERM(64)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .primary_clock_i(pclk), .secondary_clock_i(sclk), .ext_in_i(ext),
    .init_oe_pin_i(init_pin), .output_load_diag_input_i(ol), .state_load_diag_input_i(sl),
    .state_readout_diag_input_i(ro), .sequencer_output_pins_i(pin_lvl),
    .sequencer_output_pins_o(pin_o), .sequencer_output_pins_oe_o(pin_oe));
  seqrd_fixture fix (.clk_i(clk_i), .pulse_i(pulse), .drv_en_i(drv_en), .drv_val_i(drv_val),
    .dut_pin_i(pin_o), .dut_oe_i(pin_oe), .pin_clk_o(pclk), .busy_o(busy), .pin_o(pin_lvl));
  // second pin clock for the upper half
  seqrd_fixture fix2 (.clk_i(clk_i), .pulse_i(pulse2), .drv_en_i(1'h0), .drv_val_i(8'h00),
    .dut_pin_i(pin_o), .dut_oe_i(pin_oe), .pin_clk_o(sclk), .busy_o(busy2), .pin_o());
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'h1 && n < 50);
    rd = rdat;
    chk("bus ack", 32'(ack), 32'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rd_chk
  task automatic pulse_clk();
    pulse <= 1'h1;
    @(posedge clk_i);
    pulse <= 1'h0;
    @(posedge clk_i);
    while (busy === 1'h1)
      @(posedge clk_i);
    tick(8);
  endtask : pulse_clk
  task automatic pulse_secondary_clock();
    pulse2 <= 1'h1;
    @(posedge clk_i);
    pulse2 <= 1'h0;
    @(posedge clk_i);
    while (busy2 === 1'h1)
      @(posedge clk_i);
    tick(8);
  endtask : pulse_secondary_clock
  // fixture drives only in load modes
  task automatic mode(input logic s, input logic o, input logic r, input logic [7:0] v);
    sl <= s;
    ol <= o;
    ro <= r;
    drv_val <= v;
    drv_en <= s | o;
    tick(8);
  endtask : mode
  task automatic fuse(input logic [7:0] a, input seqrd_pkg::seqrd_fuse_t f);
    wb(1'h1, `SEQRD_ADR_FUSE_ADDR, {24'h0, a});
    wb(1'h1, `SEQRD_ADR_FUSE_W0, f[31:0]);
    wb(1'h1, `SEQRD_ADR_FUSE_W1, f[63:32]);
    wb(1'h1, `SEQRD_ADR_FUSE_W2, {9'h0, f[86:64]});
    wb(1'h1, `SEQRD_ADR_FUSE_GO, 32'h0);
  endtask : fuse
  task automatic t_reset();
    chk("pins", 32'(pin_o), 32'hff);
    chk("oe", 32'(pin_oe), 32'hff);
    rd_chk("status", `SEQRD_ADR_STATUS, 32'hffff);
    rd_chk("cfg", `SEQRD_ADR_CFG, 32'h1);
    rd_chk("pattern", `SEQRD_ADR_INIT_PAT, 32'h0);
    wb(1'h1, 8'h20, 32'hffff);
    rd_chk("unmapped", 8'h20, 32'h0);
    pulse_clk();
    rd_chk("blank hold", `SEQRD_ADR_STATUS, 32'hffff);
  endtask : t_reset
  task automatic t_init();
    wb(1'h1, `SEQRD_ADR_INIT_PAT, 32'h3c5a);
    init_pin <= 1'h1;
    tick(8);
    chk("init pins", 32'(pin_o), 32'h3c);
    rd_chk("init status", `SEQRD_ADR_STATUS, 32'h3c5a);
    mode(1'h1, 1'h0, 1'h0, 8'h11);
    pulse_clk();
    rd_chk("init hold", `SEQRD_ADR_STATUS, 32'h3c5a);
  endtask : t_init
  task automatic t_load();
    init_pin <= 1'h0;
    mode(1'h1, 1'h0, 1'h0, 8'ha5);
    chk("load oe", 32'(pin_oe), 32'h0);
    pulse_clk();
    rd_chk("first pulse", `SEQRD_ADR_STATUS, 32'h3c5a);
    pulse_clk();
    rd_chk("state load", `SEQRD_ADR_STATUS, 32'h3ca5);
    mode(1'h0, 1'h1, 1'h0, 8'h96);
    pulse_clk();
    rd_chk("output load", `SEQRD_ADR_STATUS, 32'h96a5);
  endtask : t_load
  task automatic t_read();
    mode(1'h0, 1'h0, 1'h1, 8'h00);
    chk("readout pins", 32'(pin_o), 32'ha5);
    pulse_clk();
    rd_chk("readout hold", `SEQRD_ADR_STATUS, 32'h96a5);
    mode(1'h0, 1'h0, 1'h0, 8'h00);
    chk("normal pins", 32'(pin_o), 32'h96);
  endtask : t_read
  task automatic t_jk();
    seqrd_pkg::seqrd_fuse_t f;
    f = '0;
    f.term_en = 1'h1;
    f.or_j = 16'h0101;
    f.or_k = 16'h0401;
    fuse(8'h00, f);
    f.or_j = 16'h0000;
    f.or_k = 16'h8000;
    fuse(8'h3f, f);
    tick(140);
    pulse_clk();
    rd_chk("jk step", `SEQRD_ADR_STATUS, 32'h13a4);
    chk("jk pins", 32'(pin_o), 32'h13);
    tick(140);
    pulse_clk();
    rd_chk("toggle back", `SEQRD_ADR_STATUS, 32'h13a5);
  endtask : t_jk
  task automatic t_oe();
    wb(1'h1, `SEQRD_ADR_CFG, 32'h0);
    init_pin <= 1'h1;
    tick(8);
    chk("oe off", 32'(pin_oe), 32'h0);
    rd_chk("oe regs", `SEQRD_ADR_STATUS, 32'h13a5);
    init_pin <= 1'h0;
    tick(8);
    chk("oe on", 32'(pin_oe), 32'hff);
    chk("oe pins", 32'(pin_o), 32'h13);
  endtask : t_oe
  // complement array, input term and split clocks
  task automatic t_comp();
    seqrd_pkg::seqrd_fuse_t f;
    f = '0;
    f.term_en = 1'h1;
    f.comp_con = 2'h1;
    f.and_t = 26'h000_0800;
    f.or_j = 16'h0042;
    f.or_k = 16'h0042;
    fuse(8'h00, f);
    f = '0;
    f.term_en = 1'h1;
    f.and_t = 26'h100_0000;
    f.or_j = 16'h0800;
    fuse(8'h3f, f);
    tick(140);
    pulse_clk();
    rd_chk("complement term", `SEQRD_ADR_STATUS, 32'h1ba5);
    ext <= 16'h0800;
    tick(140);
    pulse_clk();
    rd_chk("input term", `SEQRD_ADR_STATUS, 32'h1be7);
    wb(1'h1, `SEQRD_ADR_CFG, 32'h2);
    pulse_clk();
    rd_chk("lower half", `SEQRD_ADR_STATUS, 32'h1be5);
    pulse_secondary_clock();
    rd_chk("upper half", `SEQRD_ADR_STATUS, 32'h1ba5);
  endtask : t_comp
  // hang guard
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'h1;
    @(posedge clk_i);
    t_reset();
    t_init();
    t_load();
    t_read();
    t_jk();
    t_oe();
    t_comp();
    give_verdict();
  end
endmodule : tb_top
